// ### rtl/cae_pkg.sv
// Purpose: shared constants and types of the arithmetic/logic execution block
// Assumes: one core clock, decoded operations arrive as one-hot codes
// Notes: clock figures count core clocks from the start cycle to the done cycle

package cae_pkg;

	// ------------------------------------------------------------------
	// operations and addressing forms
	// ------------------------------------------------------------------
	typedef enum logic [10:0] {
		CAE_OP_SUB    = 11'h001, // plain difference
		CAE_OP_BORROW_DIFFERENCE   = 11'h002, // difference with borrow
		CAE_OP_AND    = 11'h004, // bitwise conjunction
		CAE_OP_NEG    = 11'h008, // twos negation
		CAE_OP_SIGN_EXTENSION   = 11'h010, // sign extension
		CAE_OP_LEA    = 11'h020, // effective address load
		CAE_OP_MULS16 = 11'h040, // signed multiply word
		CAE_OP_MULU8  = 11'h080, // unsigned multiply byte
		CAE_OP_MULU16 = 11'h100, // unsigned multiply word
		CAE_OP_DIVU16 = 11'h200, // unsigned divide word (16 by 8)
		CAE_OP_DIVU32 = 11'h400  // unsigned divide double (32 by 16)
	} cae_op_t;

	typedef enum logic [5:0] {
		CAE_AM_REG   = 6'h01, // register operand
		CAE_AM_IND   = 6'h02, // plain register-indirect
		CAE_AM_INC   = 6'h04, // register-indirect, auto-increment
		CAE_AM_OFF8  = 6'h08, // register-indirect, 8-bit offset
		CAE_AM_OFF16 = 6'h10, // register-indirect, 16-bit offset
		CAE_AM_DIR   = 6'h20  // directly addressed memory
	} cae_amode_t;

	typedef enum logic [1:0] {
		CAE_ST_IDLE = 2'b01, // waiting for start
		CAE_ST_RUN  = 2'b10  // counting out the execution time
	} cae_state_t;

	// ------------------------------------------------------------------
	// execution times in core clocks
	// ------------------------------------------------------------------
	localparam logic [4:0] CAE_CLK_REG = 5'h03;
	localparam logic [4:0] CAE_CLK_IND = 5'h04;
	localparam logic [4:0] CAE_CLK_INC = 5'h05;
	localparam logic [4:0] CAE_CLK_OFF = 5'h06;
	localparam logic [4:0] CAE_CLK_DIR = 5'h04;
	localparam logic [4:0] CAE_CLK_LEA = 5'h03;
	localparam logic [4:0] CAE_CLK_UNARY = 5'h03;
	localparam logic [4:0] CAE_CLK_MUL = 5'h0c;
	localparam logic [4:0] CAE_CLK_DIVW = 5'h0c;
	localparam logic [4:0] CAE_CLK_DIVD = 5'h16;

	// ------------------------------------------------------------------
	// instruction lengths in bytes
	// ------------------------------------------------------------------
	localparam logic [2:0] CAE_LEN_BASE = 3'h2;  // reg, indirect, auto-increment
	localparam logic [2:0] CAE_LEN_OFF8 = 3'h3;
	localparam logic [2:0] CAE_LEN_OFF16 = 3'h4;
	localparam logic [2:0] CAE_LEN_DIR = 3'h3;
	localparam logic [2:0] CAE_LEN_IMM8 = 3'h1;  // extra bytes of an 8-bit immediate
	localparam logic [2:0] CAE_LEN_IMM16 = 3'h2; // extra bytes of a 16-bit immediate

	// ------------------------------------------------------------------
	// field layouts and reset values
	// ------------------------------------------------------------------
	localparam logic [15:0] CAE_INC_BYTE = 16'h0001;
	localparam logic [15:0] CAE_INC_WORD = 16'h0002;
	localparam int CAE_BYTE_MSB = 7;
	localparam int CAE_WORD_MSB = 15;
	localparam logic [15:0] CAE_WORD_RST = 16'h0000;
	localparam logic [4:0] CAE_CNT_RST = 5'h00;
	localparam logic [2:0] CAE_LEN_RST = 3'h0;

endpackage

// ### rtl/cae_exec.sv
// Purpose: execution datapath for difference, conjunction, multiply, divide,
//          effective address, negate and sign extend operations
// Assumes: memory answers a read in the cycle mem_rd is high; operands are
//          held valid by the core only in the start cycle
// Notes: fixed execution times, results appear with the done pulse
//
// How it works
// RULE_01 - word divide 16 by 8 in 12 clocks
// RULE_02 - double divide 32 by 16 in 22
// RULE_03 - address sum into destination in 3 clocks
// RULE_04 - signed 16 by 16 multiply, 12 clocks
// RULE_05 - unsigned 8 by 8 multiply, 12 clocks
// RULE_06 - unsigned 16 by 16 multiply, 12 clocks
// RULE_07 - negate destination, 2 bytes, 3 clocks
// RULE_08 - fill destination with previous sign, 3 clocks
// RULE_09 - plain indirect difference, 2 bytes, 4 clocks
// RULE_10 - offset indirect difference takes 6 clocks
// RULE_11 - auto-increment difference, 5 clocks, pointer advances
// RULE_12 - direct memory difference, 3 bytes, 4 clocks
// RULE_13 - immediate from register, 3 clocks
// RULE_14 - immediate from direct memory, 4 clocks
// RULE_15 - immediate to offset indirect, 6 clocks
// RULE_16 - borrow difference subtracts carry as borrow
// RULE_17 - immediate to indirect 4, auto-increment 5
// RULE_18 - register conjunction, 2 bytes, 3 clocks
// RULE_19 - plain indirect conjunction, 4 clocks
// RULE_20 - offset8 indirect conjunction, 3 bytes, 6
// RULE_21 - pointer advances by operand size
// RULE_22 - divide halves defined, overflow and zero flagged

`timescale 1ns/1ps

module cae_exec
	import cae_pkg::*;
(
	input wire logic clk, // core clock
	input wire logic rstn, // asynchronous reset, active low
	input wire logic start, // take the operation below
	output logic ready, // idle and able to take start
	input wire cae_op_t op, // decoded operation
	input wire cae_amode_t amode, // addressing form of the memory/source operand
	input wire logic word_op, // 1 word, 0 byte
	input wire logic imm_src, // source is immediate data
	input wire logic imm16, // immediate is 16 bits, else 8
	input wire logic mem_dst, // memory operand is the destination
	input wire logic [15:0] dst_val, // destination register contents
	input wire logic [15:0] dst_hi_val, // high word of a destination pair
	input wire logic [15:0] src_val, // source register contents
	input wire logic [15:0] ptr_val, // pointer register contents
	input wire logic [15:0] imm_val, // immediate data, low bits used
	input wire logic [15:0] offset_val, // offset, 8-bit form in low byte
	input wire logic [15:0] direct_addr, // direct memory address
	input wire logic carry_in, // current carry flag
	input wire logic last_sign, // sign of the previous result
	output logic mem_rd, // memory read strobe
	output logic mem_wr, // memory write strobe
	output logic [15:0] mem_addr, // memory operand address
	output logic [15:0] mem_wdata, // memory write data
	input wire logic [15:0] mem_rdata, // memory read data
	output logic done, // one-cycle completion pulse
	output logic reg_wr, // write res_lo into the destination register
	output logic reg_hi_wr, // write res_hi into the pair high register
	output logic [15:0] res_lo, // result low word
	output logic [15:0] res_hi, // result high word
	output logic ptr_wr, // write ptr_next into the pointer register
	output logic [15:0] ptr_next, // advanced pointer value
	output logic flag_c, // carry / borrow
	output logic flag_v, // overflow, also divide error
	output logic flag_z, // zero
	output logic flag_n, // negative
	output logic div_err, // divide by zero or quotient overflow
	output logic [2:0] instr_len, // instruction length in bytes
	output logic [4:0] instr_clk // execution time in clocks
);

	// ------------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------------

	// execution time for an operation and addressing form
	function automatic logic [4:0] calc_clk(input cae_op_t o, input cae_amode_t a);
		logic [4:0] c;
		c = CAE_CLK_REG;
		case (o)
			CAE_OP_MULS16, CAE_OP_MULU8, CAE_OP_MULU16: c = CAE_CLK_MUL; // RULE_04 RULE_05 RULE_06
			CAE_OP_DIVU16: c = CAE_CLK_DIVW; // RULE_01
			CAE_OP_DIVU32: c = CAE_CLK_DIVD; // RULE_02
			CAE_OP_LEA: c = CAE_CLK_LEA; // RULE_03
			CAE_OP_NEG, CAE_OP_SIGN_EXTENSION: c = CAE_CLK_UNARY; // RULE_07 RULE_08
			default: begin
				case (a)
					CAE_AM_IND: c = CAE_CLK_IND; // RULE_09 RULE_17 RULE_19
					CAE_AM_INC: c = CAE_CLK_INC; // RULE_11 RULE_17
					CAE_AM_OFF8, CAE_AM_OFF16: c = CAE_CLK_OFF; // RULE_10 RULE_15 RULE_20
					CAE_AM_DIR: c = CAE_CLK_DIR; // RULE_12 RULE_14
					default: c = CAE_CLK_REG; // RULE_13 RULE_16 RULE_18
				endcase
			end
		endcase
		return c;
	endfunction

	// instruction length for an operation, form and immediate width
	function automatic logic [2:0] calc_len(input cae_op_t o, input cae_amode_t a,
		input logic is_imm, input logic is16);
		logic [2:0] l;
		logic [2:0] ext;
		l = CAE_LEN_BASE;
		ext = is16 ? CAE_LEN_IMM16 : CAE_LEN_IMM8;
		case (o)
			CAE_OP_MULS16, CAE_OP_MULU16, CAE_OP_DIVU32: begin
				l = is_imm ? 3'(CAE_LEN_BASE + CAE_LEN_IMM16) : CAE_LEN_BASE; // RULE_02 RULE_04 RULE_06
			end
			CAE_OP_MULU8, CAE_OP_DIVU16: begin
				l = is_imm ? 3'(CAE_LEN_BASE + CAE_LEN_IMM8) : CAE_LEN_BASE; // RULE_01 RULE_05
			end
			CAE_OP_NEG, CAE_OP_SIGN_EXTENSION: l = CAE_LEN_BASE; // RULE_07 RULE_08
			default: begin
				case (a)
					CAE_AM_OFF8: l = CAE_LEN_OFF8; // RULE_10 RULE_20
					CAE_AM_OFF16: l = CAE_LEN_OFF16; // RULE_03 RULE_10
					CAE_AM_DIR: l = CAE_LEN_DIR; // RULE_12
					default: l = CAE_LEN_BASE; // RULE_09 RULE_11 RULE_18 RULE_19
				endcase
				if (is_imm && o != CAE_OP_LEA) begin
					l = 3'(l + ext); // RULE_13 RULE_14 RULE_15 RULE_17
				end
			end
		endcase
		return l;
	endfunction

	// sign-extended offset of the form in use
	function automatic logic [15:0] eff_off(input cae_amode_t a, input logic [15:0] off);
		logic [15:0] r;
		r = CAE_WORD_RST;
		if (a == CAE_AM_OFF8) begin
			r = {{8{off[CAE_BYTE_MSB]}}, off[7:0]};
		end else if (a == CAE_AM_OFF16) begin
			r = off;
		end
		return r;
	endfunction

	// ------------------------------------------------------------------
	// state and latched operands
	// ------------------------------------------------------------------
	cae_state_t state_q; // control state
	logic [4:0] cnt_q; // remaining clocks
	cae_op_t op_q; // latched operation
	cae_amode_t am_q; // latched addressing form
	logic word_q; // word size
	logic imm_q; // immediate source
	logic mdst_q; // memory is destination
	logic cin_q; // latched carry
	logic lsgn_q; // latched previous sign
	logic [15:0] a_q; // destination register operand
	logic [15:0] ahi_q; // pair high word
	logic [15:0] b_q; // source register or immediate operand
	logic [15:0] ptr_q; // pointer contents
	logic [15:0] mdat_q; // captured memory operand
	logic [15:0] addr_q; // memory address
	logic rd_q; // read strobe
	logic uses_mem; // operation touches memory
	logic last; // final counting cycle

	assign uses_mem = (am_q != CAE_AM_REG) && (op_q == CAE_OP_SUB || op_q == CAE_OP_BORROW_DIFFERENCE
		|| op_q == CAE_OP_AND);
	assign last = (state_q == CAE_ST_RUN) && (cnt_q == 5'h01);
	assign ready = (state_q == CAE_ST_IDLE);
	assign mem_rd = rd_q;
	assign mem_addr = addr_q;

	// state and clock counter
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state_q <= CAE_ST_IDLE;
			cnt_q <= CAE_CNT_RST;
		end else begin
			case (state_q)
				CAE_ST_IDLE: begin
					if (start) begin
						state_q <= CAE_ST_RUN;
						cnt_q <= 5'(calc_clk(op, amode) - 5'h01);
					end
				end
				CAE_ST_RUN: begin
					cnt_q <= 5'(cnt_q - 5'h01);
					if (cnt_q == 5'h01) begin
						state_q <= CAE_ST_IDLE;
					end
				end
				default: state_q <= CAE_ST_IDLE;
			endcase
		end
	end

	// operand capture in the start cycle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			op_q <= CAE_OP_SUB;
			am_q <= CAE_AM_REG;
			word_q <= 1'b0;
			imm_q <= 1'b0;
			mdst_q <= 1'b0;
			cin_q <= 1'b0;
			lsgn_q <= 1'b0;
			a_q <= CAE_WORD_RST;
			ahi_q <= CAE_WORD_RST;
			b_q <= CAE_WORD_RST;
			ptr_q <= CAE_WORD_RST;
			instr_len <= CAE_LEN_RST;
			instr_clk <= CAE_CNT_RST;
		end else if (ready && start) begin
			op_q <= op;
			am_q <= amode;
			word_q <= word_op;
			imm_q <= imm_src;
			mdst_q <= mem_dst;
			cin_q <= carry_in;
			lsgn_q <= last_sign;
			a_q <= dst_val;
			ahi_q <= dst_hi_val;
			b_q <= imm_src ? (imm16 ? imm_val : {8'h00, imm_val[7:0]}) : src_val;
			ptr_q <= ptr_val;
			instr_len <= calc_len(op, amode, imm_src, imm16);
			instr_clk <= calc_clk(op, amode);
		end
	end

	// memory address and read strobe, data taken while the strobe is high
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rd_q <= 1'b0;
			addr_q <= CAE_WORD_RST;
			mdat_q <= CAE_WORD_RST;
		end else begin
			rd_q <= 1'b0;
			if (ready && start) begin
				addr_q <= (amode == CAE_AM_DIR) ? direct_addr
					: 16'(ptr_val + eff_off(amode, offset_val));
				rd_q <= (amode != CAE_AM_REG) && (op == CAE_OP_SUB || op == CAE_OP_BORROW_DIFFERENCE
					|| op == CAE_OP_AND);
			end
			if (rd_q) begin
				mdat_q <= mem_rdata;
			end
		end
	end

	// ------------------------------------------------------------------
	// combinational result of the latched operation
	// ------------------------------------------------------------------
	logic [15:0] x; // minuend / left operand
	logic [15:0] y; // subtrahend / right operand
	logic [16:0] dif; // difference with borrow out
	logic [15:0] r_lo; // result low word
	logic [15:0] r_hi; // result high word
	logic c_n; // next carry
	logic v_n; // next overflow
	logic err_n; // divide error
	logic [31:0] prod; // product
	logic [31:0] dvd; // dividend
	logic [15:0] dvs; // divisor, never zero into the divider
	logic [31:0] quo; // quotient
	logic [31:0] rem; // remainder

	always_comb begin
		x = mdst_q ? mdat_q : a_q;
		y = (mdst_q || imm_q || !uses_mem) ? b_q : mdat_q;
		dif = 17'h00000;
		r_lo = CAE_WORD_RST;
		r_hi = CAE_WORD_RST;
		c_n = cin_q;
		v_n = 1'b0;
		err_n = 1'b0;
		prod = 32'h00000000;
		dvd = 32'h00000000;
		dvs = 16'h0001;
		quo = 32'h00000000;
		rem = 32'h00000000;
		case (op_q)
			CAE_OP_SUB, CAE_OP_BORROW_DIFFERENCE, CAE_OP_NEG: begin
				if (op_q == CAE_OP_NEG) begin
					dif = 17'(17'h00000 - {1'b0, a_q}); // RULE_07
					x = CAE_WORD_RST;
					y = a_q;
				end else if (word_q) begin
					dif = 17'({1'b0, x} - {1'b0, y} - {16'h0000, cin_q & (op_q == CAE_OP_BORROW_DIFFERENCE)}); // RULE_16
				end else begin
					dif = 17'({9'h000, x[7:0]} - {9'h000, y[7:0]}
						- {16'h0000, cin_q & (op_q == CAE_OP_BORROW_DIFFERENCE)}); // RULE_16
				end
				r_lo = dif[15:0];
				if (word_q || op_q == CAE_OP_NEG) begin
					c_n = dif[16];
					v_n = (x[CAE_WORD_MSB] ^ y[CAE_WORD_MSB]) & (x[CAE_WORD_MSB] ^ dif[15]);
				end else begin
					r_lo = {8'h00, dif[7:0]};
					c_n = dif[8];
					v_n = (x[CAE_BYTE_MSB] ^ y[CAE_BYTE_MSB]) & (x[CAE_BYTE_MSB] ^ dif[7]);
				end
			end
			CAE_OP_AND: begin
				r_lo = word_q ? (x & y) : {8'h00, x[7:0] & y[7:0]}; // RULE_18 RULE_19 RULE_20
			end
			CAE_OP_SIGN_EXTENSION: r_lo = {16{lsgn_q}}; // RULE_08
			CAE_OP_LEA: r_lo = 16'(ptr_q + eff_off(am_q, addr_q - ptr_q)); // RULE_03
			CAE_OP_MULS16: begin
				// widen both operands first so the product keeps all 32 bits
				prod = 32'($signed(a_q)) * 32'($signed(b_q)); // RULE_04
				{r_hi, r_lo} = prod;
			end
			CAE_OP_MULU8: begin
				prod = {16'h0000, 16'(a_q[7:0]) * 16'(b_q[7:0])}; // RULE_05
				r_lo = prod[15:0];
			end
			CAE_OP_MULU16: begin
				prod = 32'(a_q) * 32'(b_q); // RULE_06
				{r_hi, r_lo} = prod;
			end
			CAE_OP_DIVU16, CAE_OP_DIVU32: begin
				if (op_q == CAE_OP_DIVU16) begin
					dvd = {16'h0000, a_q}; // RULE_01
					dvs = {8'h00, b_q[7:0]};
				end else begin
					dvd = {ahi_q, a_q}; // RULE_02
					dvs = b_q;
				end
				err_n = (dvs == 16'h0000); // RULE_22
				if (err_n) begin
					dvs = 16'h0001;
				end
				quo = dvd / {16'h0000, dvs};
				rem = dvd % {16'h0000, dvs};
				if (op_q == CAE_OP_DIVU16) begin
					err_n = err_n | (quo[31:8] != 24'h000000); // RULE_22
					r_lo = {rem[7:0], quo[7:0]}; // RULE_22
				end else begin
					err_n = err_n | (quo[31:16] != 16'h0000); // RULE_22
					r_lo = quo[15:0]; // RULE_22
					r_hi = rem[15:0];
				end
				v_n = err_n;
				c_n = 1'b0;
			end
			default: r_lo = CAE_WORD_RST;
		endcase
	end

	// results, strobes and flags registered at the final clock
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			done <= 1'b0;
			reg_wr <= 1'b0;
			reg_hi_wr <= 1'b0;
			mem_wr <= 1'b0;
			ptr_wr <= 1'b0;
			res_lo <= CAE_WORD_RST;
			res_hi <= CAE_WORD_RST;
			mem_wdata <= CAE_WORD_RST;
			ptr_next <= CAE_WORD_RST;
			flag_c <= 1'b0;
			flag_v <= 1'b0;
			flag_z <= 1'b0;
			flag_n <= 1'b0;
			div_err <= 1'b0;
		end else begin
			done <= last;
			reg_wr <= 1'b0;
			reg_hi_wr <= 1'b0;
			mem_wr <= 1'b0;
			ptr_wr <= 1'b0;
			if (last) begin
				res_lo <= r_lo;
				res_hi <= r_hi;
				mem_wdata <= r_lo;
				div_err <= err_n;
				flag_c <= c_n;
				flag_v <= v_n;
				flag_z <= word_q ? (r_lo == 16'h0000) : (r_lo[7:0] == 8'h00);
				flag_n <= word_q ? r_lo[CAE_WORD_MSB] : r_lo[CAE_BYTE_MSB];
				// a failed divide leaves the destination untouched
				reg_wr <= !(uses_mem && mdst_q) && !err_n; // RULE_22
				reg_hi_wr <= (op_q == CAE_OP_MULS16 || op_q == CAE_OP_MULU16
					|| op_q == CAE_OP_DIVU32) && !err_n; // RULE_02 RULE_04 RULE_06
				mem_wr <= uses_mem && mdst_q; // RULE_09
				ptr_wr <= uses_mem && (am_q == CAE_AM_INC); // RULE_11
				ptr_next <= 16'(ptr_q + (word_q ? CAE_INC_WORD : CAE_INC_BYTE)); // RULE_21
			end
		end
	end

endmodule

// ### test/cae_exec_sva.sv
// Purpose: concurrent checks on timing, strobes and results of the exec block
// Assumes: one core clock, reset asynchronous and active low
// Notes: a small cycle counter ties done to the reported execution time
`timescale 1ns/1ps
module cae_exec_chk
	import cae_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic start,
	input wire logic ready,
	input wire cae_op_t op,
	input wire cae_amode_t amode,
	input wire logic word_op,
	input wire logic [15:0] dst_val,
	input wire logic [15:0] ptr_val,
	input wire logic last_sign,
	input wire logic mem_rd,
	input wire logic done,
	input wire logic reg_wr,
	input wire logic reg_hi_wr,
	input wire logic [15:0] res_lo,
	input wire logic ptr_wr,
	input wire logic [15:0] ptr_next,
	input wire logic flag_v,
	input wire logic div_err,
	input wire logic [4:0] instr_clk
);
	// ------------------------------------------------------------
	// helper: cycles since the operation was taken
	// ------------------------------------------------------------
	logic [4:0] cnt_q; // 1 in the cycle after the take edge
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_q <= 5'h00;
		end else if (start && ready) begin
			cnt_q <= 5'h01;
		end else if (!ready) begin
			cnt_q <= cnt_q + 5'h01;
		end
	end
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	// an operation is taken
	sequence s_take;
		start && ready;
	endsequence
	// a memory-operand difference or conjunction is taken
	sequence s_mem;
		s_take ##0 (op inside {CAE_OP_SUB, CAE_OP_BORROW_DIFFERENCE, CAE_OP_AND} && amode != CAE_AM_REG);
	endsequence
	property p_done_time;
		done |-> cnt_q == instr_clk;
	endproperty
	a_done_time: assert property (p_done_time) else $error("done off its time");
	property p_divw;
		s_take ##0 (op == CAE_OP_DIVU16) |-> ##1 (instr_clk == 5'h0c) ##11 done;
	endproperty
	a_divw: assert property (p_divw) else $error("word divide time");
	property p_divd;
		s_take ##0 (op == CAE_OP_DIVU32) |-> ##1 (instr_clk == 5'h16) ##21 done;
	endproperty
	a_divd: assert property (p_divd) else $error("double divide time");
	property p_mul;
		s_take ##0 (op inside {CAE_OP_MULS16, CAE_OP_MULU8, CAE_OP_MULU16}) |-> ##12 done;
	endproperty
	a_mul: assert property (p_mul) else $error("multiply time");
	property p_unary;
		s_take ##0 (op inside {CAE_OP_NEG, CAE_OP_SIGN_EXTENSION, CAE_OP_LEA}) |->
			##1 !done ##1 !done ##1 (done && reg_wr);
	endproperty
	a_unary: assert property (p_unary) else $error("short op time");
	property p_memrd;
		s_mem |-> ##1 (mem_rd && !ready);
	endproperty
	a_memrd: assert property (p_memrd) else $error("operand read missing");
	property p_inc;
		logic [15:0] p;
		logic w;
		(s_mem ##0 (amode == CAE_AM_INC, p = ptr_val, w = word_op)) |->
			##5 (done && ptr_wr && ptr_next == p + (w ? 16'h0002 : 16'h0001));
	endproperty
	a_inc: assert property (p_inc) else $error("pointer advance wrong");
	property p_err;
		done && div_err |-> !reg_wr && !reg_hi_wr && flag_v;
	endproperty
	a_err: assert property (p_err) else $error("divide error wrote result");
	property p_neg;
		logic [15:0] d;
		(s_take ##0 (op == CAE_OP_NEG, d = dst_val)) |-> ##3 (done && res_lo == 16'h0000 - d);
	endproperty
	a_neg: assert property (p_neg) else $error("negate result wrong");
	property p_sign_extension;
		logic s;
		(s_take ##0 (op == CAE_OP_SIGN_EXTENSION, s = last_sign)) |-> ##3 (done && res_lo == {16{s}});
	endproperty
	a_sign_extension: assert property (p_sign_extension) else $error("sign fill wrong");
endmodule
bind cae_exec cae_exec_chk u_chk (.*);

// ### test/test_cpu_arith_logic_exec.sv
// Purpose: self-checking bench for the arithmetic/logic execution block
// Assumes: memory answers in the strobe cycle; inputs move on falling edges
// Notes: table rows run back to back; divide faults and reset follow
`timescale 1ns/1ps
module test_cpu_arith_logic_exec
	import cae_pkg::*;
;
	// ------------------------------------------------------------
	// signals
	// ------------------------------------------------------------
	// one case: flags f = {word, immediate, 16-bit immediate, memory destination}
	typedef struct {
		cae_op_t op;
		cae_amode_t am;
		logic [3:0] f;
		logic [31:0] d;
		logic [15:0] s;
		logic [15:0] m;
		logic [31:0] e;
		logic [2:0] len;
		logic [4:0] n;
	} cae_row_t;
	logic clk, rstn, start, ready, word_op, imm_src, imm16, mem_dst, carry_in, last_sign;
	cae_op_t op;
	cae_amode_t amode;
	logic [15:0] dst_val, dst_hi_val, src_val, ptr_val, imm_val, offset_val, direct_addr;
	logic [15:0] mem_rdata = 16'h0000;
	logic [15:0] mem_data; // what memory returns on a read
	logic mem_rd, mem_wr, done, reg_wr, reg_hi_wr, ptr_wr, flag_c, flag_v, flag_z, flag_n, div_err;
	logic [15:0] mem_addr, mem_wdata, res_lo, res_hi, ptr_next;
	logic [2:0] instr_len;
	logic [4:0] instr_clk;
	int fail_count, num_checks;
	cae_row_t rows[] = '{
		'{CAE_OP_SUB, CAE_AM_REG, 4'h8, 32'h10, 16'h3, 16'h0, 32'hd, 3'h2, 5'h03},
		'{CAE_OP_SUB, CAE_AM_REG, 4'he, 32'h1234, 16'h234, 16'h0, 32'h1000, 3'h4, 5'h03},
		'{CAE_OP_SUB, CAE_AM_REG, 4'hc, 32'h100, 16'h1, 16'h0, 32'hff, 3'h3, 5'h03},
		'{CAE_OP_SUB, CAE_AM_IND, 4'h8, 32'h50, 16'h0, 16'h10, 32'h40, 3'h2, 5'h04},
		'{CAE_OP_SUB, CAE_AM_IND, 4'h9, 32'h0, 16'h10, 16'h50, 32'h40, 3'h2, 5'h04},
		'{CAE_OP_SUB, CAE_AM_OFF8, 4'h8, 32'h9, 16'h0, 16'h2, 32'h7, 3'h3, 5'h06},
		'{CAE_OP_SUB, CAE_AM_OFF16, 4'h9, 32'h0, 16'h2, 16'h9, 32'h7, 3'h4, 5'h06},
		'{CAE_OP_SUB, CAE_AM_OFF8, 4'hd, 32'h0, 16'h2, 16'h9, 32'h7, 3'h4, 5'h06},
		'{CAE_OP_SUB, CAE_AM_OFF16, 4'hf, 32'h0, 16'h2, 16'h9, 32'h7, 3'h6, 5'h06},
		'{CAE_OP_SUB, CAE_AM_INC, 4'h8, 32'h9, 16'h0, 16'h2, 32'h7, 3'h2, 5'h05},
		'{CAE_OP_SUB, CAE_AM_DIR, 4'h8, 32'h9, 16'h0, 16'h2, 32'h7, 3'h3, 5'h04},
		'{CAE_OP_SUB, CAE_AM_DIR, 4'h9, 32'h0, 16'h2, 16'h9, 32'h7, 3'h3, 5'h04},
		'{CAE_OP_SUB, CAE_AM_DIR, 4'hd, 32'h0, 16'h2, 16'h9, 32'h7, 3'h4, 5'h04},
		'{CAE_OP_SUB, CAE_AM_DIR, 4'hf, 32'h0, 16'h2, 16'h9, 32'h7, 3'h5, 5'h04},
		'{CAE_OP_SUB, CAE_AM_IND, 4'hd, 32'h0, 16'h2, 16'h9, 32'h7, 3'h3, 5'h04},
		'{CAE_OP_SUB, CAE_AM_INC, 4'h5, 32'h0, 16'h2, 16'h9, 32'h7, 3'h3, 5'h05},
		'{CAE_OP_BORROW_DIFFERENCE, CAE_AM_REG, 4'h8, 32'h10, 16'h3, 16'h0, 32'hc, 3'h2, 5'h03},
		'{CAE_OP_BORROW_DIFFERENCE, CAE_AM_IND, 4'h9, 32'h0, 16'h3, 16'h10, 32'hc, 3'h2, 5'h04},
		'{CAE_OP_AND, CAE_AM_REG, 4'h8, 32'hff0, 16'h3c3c, 16'h0, 32'hc30, 3'h2, 5'h03},
		'{CAE_OP_AND, CAE_AM_IND, 4'h9, 32'h0, 16'h3c3c, 16'hff0, 32'hc30, 3'h2, 5'h04},
		'{CAE_OP_AND, CAE_AM_IND, 4'h8, 32'hff0, 16'h0, 16'h3c3c, 32'hc30, 3'h2, 5'h04},
		'{CAE_OP_AND, CAE_AM_OFF8, 4'h9, 32'h0, 16'h3c3c, 16'hff0, 32'hc30, 3'h3, 5'h06},
		'{CAE_OP_NEG, CAE_AM_REG, 4'h8, 32'h1, 16'h0, 16'h0, 32'hffff, 3'h2, 5'h03},
		'{CAE_OP_SIGN_EXTENSION, CAE_AM_REG, 4'h8, 32'h0, 16'h0, 16'h0, 32'hffff, 3'h2, 5'h03},
		'{CAE_OP_LEA, CAE_AM_OFF8, 4'h8, 32'h0, 16'h0, 16'h0, 32'h1004, 3'h3, 5'h03},
		'{CAE_OP_LEA, CAE_AM_OFF16, 4'h8, 32'h0, 16'h0, 16'h0, 32'h1004, 3'h4, 5'h03},
		'{CAE_OP_MULU8, CAE_AM_REG, 4'h0, 32'h1210, 16'h3410, 16'h0, 32'h100, 3'h2, 5'h0c},
		'{CAE_OP_MULU8, CAE_AM_REG, 4'h4, 32'h10, 16'h10, 16'h0, 32'h100, 3'h3, 5'h0c},
		'{CAE_OP_MULU16, CAE_AM_REG, 4'he, 32'h100, 16'h100, 16'h0, 32'h10000, 3'h4, 5'h0c},
		'{CAE_OP_MULS16, CAE_AM_REG, 4'h8, 32'hffff, 16'h2, 16'h0, 32'hfffffffe, 3'h2, 5'h0c},
		'{CAE_OP_DIVU16, CAE_AM_REG, 4'h8, 32'h64, 16'h7, 16'h0, 32'h20e, 3'h2, 5'h0c},
		'{CAE_OP_DIVU16, CAE_AM_REG, 4'hc, 32'h64, 16'h7, 16'h0, 32'h20e, 3'h3, 5'h0c},
		'{CAE_OP_DIVU32, CAE_AM_REG, 4'he, 32'h10000, 16'h3, 16'h0, 32'h15555, 3'h4, 5'h16},
		'{CAE_OP_DIVU32, CAE_AM_REG, 4'h8, 32'h10000, 16'h3, 16'h0, 32'h15555, 3'h2, 5'h16}
	};
	cae_exec dut (.*);
	// ------------------------------------------------------------
	// clock, memory and helpers
	// ------------------------------------------------------------
	// 50 MHz core clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// memory answers in the strobe cycle, else the bus keeps toggling
	always @(negedge clk) begin
		mem_rdata <= mem_rd ? mem_data : ~mem_rdata;
	end
	// compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// issue one operation and check it at its done pulse
	task automatic go(input cae_row_t r, input logic err);
		int n;
		logic [15:0] adr;
		op = r.op;
		amode = r.am;
		{word_op, imm_src, imm16, mem_dst} = r.f;
		{dst_hi_val, dst_val} = r.d;
		src_val = r.s;
		imm_val = r.s;
		mem_data = r.m;
		start = 1'b1;
		n = 0;
		adr = (r.am == CAE_AM_DIR) ? 16'h2000 : (r.am inside {CAE_AM_OFF8, CAE_AM_OFF16}) ? 16'h1004 : 16'h1000;
		do begin
			@(negedge clk);
			start = 1'b0;
			n++;
		end while (done !== 1'b1 && n < 40);
		chk(n, r.n);
		chk({instr_len, instr_clk}, {r.len, r.n});
		chk({div_err, reg_wr, mem_wr}, err ? 3'b100 : {1'b0, !r.f[0], r.f[0]});
		if (err) chk(flag_v, 1'b1);
		if (!err) chk(r.f[0] ? mem_wdata : res_lo, r.e[15:0]);
		if (!err) chk({flag_z, flag_n}, r.f[3] ? {r.e[15:0] == 16'h0000, r.e[15]} : {r.e[7:0] == 8'h00, r.e[7]});
		if (r.op inside {CAE_OP_SUB, CAE_OP_BORROW_DIFFERENCE, CAE_OP_NEG}) chk(flag_c, r.op == CAE_OP_NEG);
		if (!err && r.op inside {CAE_OP_MULS16, CAE_OP_MULU16, CAE_OP_DIVU32}) chk({reg_hi_wr, res_hi}, {1'b1, r.e[31:16]});
		if (r.op inside {CAE_OP_SUB, CAE_OP_BORROW_DIFFERENCE, CAE_OP_AND} && r.am != CAE_AM_REG) chk(mem_addr, adr);
		if (r.am == CAE_AM_INC) chk({ptr_wr, ptr_next}, {1'b1, r.f[3] ? 16'h1002 : 16'h1001});
		else chk(ptr_wr, 1'b0);
	endtask
	// verdict and end of run
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	// watchdog well beyond the expected run
	initial begin
		#100000;
		fail_count++;
		summarize();
	end
	initial begin
		fail_count = 0;
		num_checks = 0;
		{rstn, start, word_op, imm_src, imm16, mem_dst} = 6'h00;
		{carry_in, last_sign} = 2'b11;
		op = CAE_OP_SUB;
		amode = CAE_AM_REG;
		{dst_val, dst_hi_val, src_val, imm_val, mem_data} = 80'h0;
		{ptr_val, offset_val, direct_addr} = {16'h1000, 16'h0004, 16'h2000};
		repeat (12) @(negedge clk);
		chk({ready, done, reg_wr, mem_rd, res_lo}, {4'h8, 16'h0000});
		rstn = 1'b1;
		@(negedge clk);
		foreach (rows[i]) go(rows[i], 1'b0);
		// zero divisor and quotient overflow
		go('{CAE_OP_DIVU16, CAE_AM_REG, 4'h8, 32'h64, 16'h0, 16'h0, 32'h0, 3'h2, 5'h0c}, 1'b1);
		go('{CAE_OP_DIVU16, CAE_AM_REG, 4'h8, 32'h1000, 16'h1, 16'h0, 32'h0, 3'h2, 5'h0c}, 1'b1);
		go('{CAE_OP_DIVU32, CAE_AM_REG, 4'h8, 32'h10000, 16'h0, 16'h0, 32'h0, 3'h2, 5'h16}, 1'b1);
		// reset in mid divide clears everything
		op = CAE_OP_DIVU32;
		start = 1'b1;
		repeat (5) @(negedge clk);
		start = 1'b0;
		rstn = 1'b0;
		#1;
		chk({ready, done, instr_clk, res_hi}, {2'b10, 5'h00, 16'h0000});
		@(negedge clk);
		rstn = 1'b1;
		go(rows[0], 1'b0);
		summarize();
	end
endmodule
